/* mfsc_defs.svh */
// Constants for the modem format and sync configuration block
`ifndef MFSC_DEFS_SVH
`define MFSC_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define MFSC_ADDR_W 6
`define MFSC_CFG_ADDR 6'h12
`define MFSC_CFG_RESET 8'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MFSC_DC_BYPASS_BIT 7
`define MFSC_MOD_HI 6
`define MFSC_MOD_LO 4
`define MFSC_MANCH_BIT 3
`define MFSC_SYNC_HI 2
`define MFSC_SYNC_LO 0
`define MFSC_SYNC_CS_BIT 2

// ----------------------------------------
// Sync qualifier sub-codes (low two bits) and their mismatch limits
// ----------------------------------------
`define MFSC_SQ_NONE 2'h0
`define MFSC_SQ_15OF16 2'h1
`define MFSC_SQ_16OF16 2'h2
`define MFSC_SQ_30OF32 2'h3
`define MFSC_MISS_15OF16 5'h01
`define MFSC_MISS_16OF16 5'h00
`define MFSC_MISS_30OF32 6'h02

// ----------------------------------------
// Datapath figures
// ----------------------------------------
`define MFSC_DC_SHIFT 4
`define MFSC_SYNC_LEN 6'h10
`define MFSC_SYNC_LEN2 6'h20
`define MFSC_TXSW_NONE 2'h0
`define MFSC_TXSW_ONE 2'h1
`define MFSC_TXSW_TWO 2'h2

`endif

/* mfsc_pkg.sv */
// Types for the modem format and sync configuration block
package mfsc_pkg;

  typedef enum logic [2:0] {
    MFSC_MOD_2FSK = 3'b000,
    MFSC_MOD_GFSK = 3'b001,
    MFSC_MOD_ASK = 3'b011,
    MFSC_MOD_4FSK = 3'b100,
    MFSC_MOD_MSK = 3'b111
  } mfsc_mod_e;

  typedef enum logic [1:0] {
    MFSC_RX_IDLE = 2'b00,
    MFSC_RX_SEARCH = 2'b01,
    MFSC_RX_LOCKED = 2'b10
  } mfsc_rx_state_e;

endpackage

/* mfsc_sync_match.sv */
// Sync word correlator: counts bit mismatches over the last 16 and 32 bits
`timescale 1ns/100ps
`include "mfsc_defs.svh"

module mfsc_sync_match #(
  parameter int WORD_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic bit_i,
  input wire logic bit_valid_i,
  input wire logic [WORD_W-1:0] sync_word_i,
  output logic [5:0] miss16_o,
  output logic [6:0] miss32_o,
  output logic full16_o,
  output logic full32_o
);
  import mfsc_pkg::*;

  logic [2*WORD_W-1:0] hist;
  logic [2*WORD_W-1:0] diff;
  logic [5:0] fill;
  logic [5:0] next_miss16;
  logic [6:0] next_miss32;

  // ----------------------------------------
  // Bit history, newest bit in bit 0
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hist <= '0;
    end else if (bit_valid_i) begin
      hist <= {hist[2*WORD_W-2:0], bit_i};
    end
  end

  // Fill count keeps a half-filled history from matching noise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fill <= '0;
    end else if (clear_i) begin
      fill <= '0;
    end else if (bit_valid_i && fill != `MFSC_SYNC_LEN2) begin
      fill <= fill + 6'h01;
    end
  end

  // ----------------------------------------
  // Per-bit comparison against the doubled word
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2 * WORD_W; g++) begin : g_cmp
      assign diff[g] = hist[g] ^ sync_word_i[g % WORD_W];
    end
  endgenerate

  always_comb begin
    next_miss16 = '0;
    next_miss32 = '0;
    for (int i = 0; i < 2 * WORD_W; i++) begin
      if (i < WORD_W) begin
        next_miss16 = next_miss16 + {5'h00, diff[i]};
      end
      next_miss32 = next_miss32 + {6'h00, diff[i]};
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      miss16_o <= '0;
      miss32_o <= '0;
      full16_o <= 1'b0;
      full32_o <= 1'b0;
    end else begin
      miss16_o <= next_miss16;
      miss32_o <= next_miss32;
      full16_o <= fill >= `MFSC_SYNC_LEN;
      full32_o <= fill == `MFSC_SYNC_LEN2;
    end
  end

endmodule

/* mfsc_top.sv */
// Modem format and sync qualifier register with the logic it steers
`timescale 1ns/100ps
`include "mfsc_defs.svh"

module mfsc_top #(
  parameter int SAMPLE_W = 12,
  parameter int SYNC_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [`MFSC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic dc_block_bypass_o,
  output mfsc_pkg::mfsc_mod_e modulation_select_o,
  output logic mod_code_valid_o,
  output logic manchester_en_o,
  input wire logic signed [SAMPLE_W-1:0] rx_sample_i,
  input wire logic rx_sample_valid_i,
  output logic signed [SAMPLE_W-1:0] demod_sample_o,
  output logic demod_sample_valid_o,
  input wire logic tx_bit_i,
  input wire logic tx_chip_strobe_i,
  output logic tx_bit_ready_o,
  output logic tx_chip_o,
  output logic tx_preamble_en_o,
  output logic [1:0] tx_sync_words_o,
  input wire logic rx_chip_i,
  input wire logic rx_chip_valid_i,
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  output logic rx_manchester_err_o,
  input wire logic [SYNC_W-1:0] sync_word_i,
  input wire logic carrier_sense_i,
  input wire logic rx_enable_i,
  output logic rx_sync_found_o,
  output logic rx_locked_o
);
  import mfsc_pkg::*;

  logic [7:0] cfg;
  logic [2:0] mod_raw;
  logic [1:0] sq_sub;
  logic sq_need_cs;
  logic signed [SAMPLE_W+`MFSC_DC_SHIFT-1:0] dc_acc;
  logic signed [SAMPLE_W-1:0] dc_avg;
  logic signed [SAMPLE_W:0] dc_diff;
  logic tx_phase;
  logic rx_half;
  logic rx_first_chip;
  logic [5:0] miss16;
  logic [6:0] miss32;
  logic full16;
  logic full32;
  logic word_hit;
  logic cs_ok;
  mfsc_rx_state_e rx_state;
  mfsc_rx_state_e next_rx_state;

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg <= `MFSC_CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == `MFSC_CFG_ADDR) begin
      cfg <= reg_wdata_i;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= (reg_addr_i == `MFSC_CFG_ADDR) ? cfg : 8'h00;
    end
  end

  assign mod_raw = cfg[`MFSC_MOD_HI:`MFSC_MOD_LO];
  assign sq_sub = cfg[`MFSC_SYNC_LO+1:`MFSC_SYNC_LO];
  assign sq_need_cs = cfg[`MFSC_SYNC_CS_BIT];
  assign dc_block_bypass_o = cfg[`MFSC_DC_BYPASS_BIT];
  assign manchester_en_o = cfg[`MFSC_MANCH_BIT];
  // Unassigned codes pass through unchanged; the flag lets the datapath know
  assign modulation_select_o = mfsc_mod_e'(mod_raw);
  assign mod_code_valid_o = (mod_raw == MFSC_MOD_2FSK) || (mod_raw == MFSC_MOD_GFSK) ||
    (mod_raw == MFSC_MOD_ASK) || (mod_raw == MFSC_MOD_4FSK) ||
    (mod_raw == MFSC_MOD_MSK);

  // ----------------------------------------
  // DC blocking filter
  // ----------------------------------------
  // A leaky average; the shift trades settling time against ripple
  assign dc_avg = SAMPLE_W'(dc_acc >>> `MFSC_DC_SHIFT);
  assign dc_diff = (SAMPLE_W + 1)'(rx_sample_i) - (SAMPLE_W + 1)'(dc_avg);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dc_acc <= '0;
    end else if (rx_sample_valid_i) begin
      dc_acc <= dc_acc + (SAMPLE_W + `MFSC_DC_SHIFT)'(dc_diff);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      demod_sample_o <= '0;
      demod_sample_valid_o <= 1'b0;
    end else begin
      demod_sample_valid_o <= rx_sample_valid_i;
      if (rx_sample_valid_i) begin
        demod_sample_o <= dc_block_bypass_o ? rx_sample_i : SAMPLE_W'(dc_diff);
      end
    end
  end

  // ----------------------------------------
  // Manchester encoder
  // ----------------------------------------
  // A one is sent as chips 1,0 and a zero as 0,1
  assign tx_bit_ready_o = !manchester_en_o || tx_phase;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_phase <= 1'b0;
      tx_chip_o <= 1'b0;
    end else if (tx_chip_strobe_i) begin
      if (manchester_en_o) begin
        tx_chip_o <= tx_phase ? ~tx_bit_i : tx_bit_i;
        tx_phase <= ~tx_phase;
      end else begin
        tx_chip_o <= tx_bit_i;
        tx_phase <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Manchester decoder
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_half <= 1'b0;
      rx_first_chip <= 1'b0;
      rx_bit_o <= 1'b0;
      rx_bit_valid_o <= 1'b0;
      rx_manchester_err_o <= 1'b0;
    end else begin
      rx_bit_valid_o <= 1'b0;
      rx_manchester_err_o <= 1'b0;
      if (rx_chip_valid_i) begin
        if (!manchester_en_o) begin
          rx_bit_o <= rx_chip_i;
          rx_bit_valid_o <= 1'b1;
          rx_half <= 1'b0;
        end else if (!rx_half) begin
          rx_first_chip <= rx_chip_i;
          rx_half <= 1'b1;
        end else begin
          rx_bit_o <= rx_first_chip;
          rx_bit_valid_o <= 1'b1;
          rx_manchester_err_o <= rx_first_chip == rx_chip_i;
          rx_half <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Transmit preamble and sync framing
  // ----------------------------------------
  always_comb begin
    case (sq_sub)
      `MFSC_SQ_NONE: tx_sync_words_o = `MFSC_TXSW_NONE;
      `MFSC_SQ_30OF32: tx_sync_words_o = `MFSC_TXSW_TWO;
      default: tx_sync_words_o = `MFSC_TXSW_ONE;
    endcase
  end
  assign tx_preamble_en_o = sq_sub != `MFSC_SQ_NONE;

  // ----------------------------------------
  // Receive sync search
  // ----------------------------------------
  mfsc_sync_match #(
    .WORD_W(SYNC_W)
  ) u_match (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(rx_state != MFSC_RX_SEARCH),
    .bit_i(rx_bit_o),
    .bit_valid_i(rx_bit_valid_o),
    .sync_word_i(sync_word_i),
    .miss16_o(miss16),
    .miss32_o(miss32),
    .full16_o(full16),
    .full32_o(full32)
  );

  always_comb begin
    case (sq_sub)
      `MFSC_SQ_15OF16: word_hit = full16 && miss16 <= {1'b0, `MFSC_MISS_15OF16};
      `MFSC_SQ_16OF16: word_hit = full16 && miss16 == {1'b0, `MFSC_MISS_16OF16};
      `MFSC_SQ_30OF32: word_hit = full32 && miss32 <= {1'b0, `MFSC_MISS_30OF32};
      default: word_hit = 1'b1;
    endcase
  end
  assign cs_ok = !sq_need_cs || carrier_sense_i;

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      MFSC_RX_IDLE: begin
        if (rx_enable_i) begin
          next_rx_state = MFSC_RX_SEARCH;
        end
      end
      MFSC_RX_SEARCH: begin
        if (!rx_enable_i) begin
          next_rx_state = MFSC_RX_IDLE;
        end else if (word_hit && cs_ok) begin
          next_rx_state = MFSC_RX_LOCKED;
        end
      end
      MFSC_RX_LOCKED: begin
        if (!rx_enable_i) begin
          next_rx_state = MFSC_RX_IDLE;
        end
      end
      default: next_rx_state = MFSC_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_state <= MFSC_RX_IDLE;
      rx_sync_found_o <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_sync_found_o <= rx_state == MFSC_RX_SEARCH && next_rx_state == MFSC_RX_LOCKED;
    end
  end

  assign rx_locked_o = rx_state == MFSC_RX_LOCKED;

endmodule

/* mfsc_peer.sv */
// Air-side peer model: plays a bit pattern into the receiver as chips
`timescale 1ns/100ps
module mfsc_peer (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic go_i,
  input wire logic manch_i,
  input wire logic [31:0] word_i,
  input wire logic [5:0] nbits_i,
  output logic chip_o,
  output logic valid_o,
  output logic busy_o
);
  logic [31:0] sh;
  logic [5:0] left;
  logic half;
  assign busy_o = left != 6'h00;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      left <= 6'h00;
      half <= 1'b0;
      valid_o <= 1'b0;
      chip_o <= 1'b0;
    end else if (go_i) begin
      sh <= word_i;
      left <= nbits_i;
    end else if (busy_o) begin
      valid_o <= 1'b1;
      chip_o <= sh[31] ^ half;
      if (!manch_i || half) begin
        sh <= sh << 1;
        left <= left - 6'h01;
      end
      half <= manch_i && !half;
    end else begin
      // Idle line keeps no stable level
      valid_o <= 1'b0;
      chip_o <= ~chip_o;
    end
  end
endmodule

/* mfsc_checker.sv */
// Assertions on the modem configuration register and its controls
`timescale 1ns/100ps
`include "mfsc_defs.svh"
module mfsc_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic dc_block_bypass_o,
  input mfsc_pkg::mfsc_mod_e modulation_select_o,
  input wire logic mod_code_valid_o,
  input wire logic manchester_en_o,
  input wire logic tx_preamble_en_o,
  input wire logic [1:0] tx_sync_words_o,
  input wire logic carrier_sense_i,
  input wire logic rx_locked_o,
  input wire logic rx_sync_found_o
);
  import mfsc_pkg::*;
  logic [7:0] cfg;
  // Shadow copy, so outputs are judged against what was written
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg <= `MFSC_CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == `MFSC_CFG_ADDR) begin
      cfg <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_lock; $rose(rx_locked_o); endsequence
  sequence s_pulse; rx_sync_found_o ##1 !rx_sync_found_o; endsequence
  property p_dc; dc_block_bypass_o == cfg[7]; endproperty
  a_dc: assert property (p_dc) else $error("dc bypass");
  property p_mod; modulation_select_o == cfg[6:4]; endproperty
  a_mod: assert property (p_mod) else $error("format");
  property p_mv; mod_code_valid_o == (cfg[6:4] inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h7}); endproperty
  a_mv: assert property (p_mv) else $error("format known");
  property p_man; manchester_en_o == cfg[3]; endproperty
  a_man: assert property (p_man) else $error("manchester");
  property p_pre; tx_preamble_en_o == (cfg[1:0] != 2'h0); endproperty
  a_pre: assert property (p_pre) else $error("preamble");
  property p_sw; tx_sync_words_o == (cfg[1:0] == 2'h3 ? 2'h2 : 2'(cfg[1:0] != 2'h0)); endproperty
  a_sw: assert property (p_sw) else $error("sync words");
  property p_cs; $rose(rx_locked_o) && cfg[2] |-> $past(carrier_sense_i); endproperty
  a_cs: assert property (p_cs) else $error("carrier");
  // Found pulse is registered on the same edge that enters the locked state
  property p_found; s_lock |-> s_pulse; endproperty
  a_found: assert property (p_found) else $error("found pulse");
endmodule
bind mfsc_top mfsc_checker chk_u (.*);

/* modem_format_sync_config_tb_top.sv */
// Self-checking bench for the modem format and sync configuration block
`timescale 1ns/100ps
module modem_format_sync_config_tb_top;
  import mfsc_pkg::*;
  logic clk_i, reset_i, reg_wr_i, reg_rd_i, rx_sample_valid_i, tx_bit_i, tx_chip_strobe_i;
  logic rx_chip_i, rx_chip_valid_i, carrier_sense_i, rx_enable_i, dc_block_bypass_o;
  logic mod_code_valid_o, manchester_en_o, demod_sample_valid_o, tx_bit_ready_o, tx_chip_o;
  logic tx_preamble_en_o, rx_bit_o, rx_bit_valid_o, rx_manchester_err_o, rx_sync_found_o;
  logic rx_locked_o, go, busy;
  logic [5:0] reg_addr_i, nbits;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] tx_sync_words_o;
  logic signed [11:0] rx_sample_i, demod_sample_o;
  logic [15:0] sync_word_i;
  logic [31:0] pword;
  mfsc_mod_e modulation_select_o;
  int miscompares, tests_run, errs;
  mfsc_top dut_u (.*);
  mfsc_peer peer_u (.clk_i(clk_i), .reset_i(reset_i), .go_i(go), .manch_i(manchester_en_o),
    .word_i(pword), .nbits_i(nbits), .chip_o(rx_chip_i), .valid_o(rx_chip_valid_i), .busy_o(busy));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Counts decoder error pulses; the peer only ever sends legal chip pairs
  always @(posedge clk_i) begin
    if (rx_manchester_err_o === 1'b1) begin
      errs++;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("%0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] d, input logic [5:0] a = 6'h12);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(output logic [7:0] d, input logic [5:0] a = 6'h12);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic t_regs;
    logic [7:0] d, v;
    rd(d);
    chk("reset value", 8'h02, d);
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], !i[0], i[2:0]};
      wr(v);
      chk("controls", {v[7:3], i inside {0, 1, 3, 4, 7}, i[1:0] != 0, i[1:0] == 3, i[1:0] == 1
        || i[1:0] == 2}, {dc_block_bypass_o, modulation_select_o, manchester_en_o,
        mod_code_valid_o, tx_preamble_en_o, tx_sync_words_o});
      rd(d);
      chk("readback", v, d);
    end
    wr(8'hFF, 6'h13);
    rd(d, 6'h13);
    chk("unmapped", 8'h00, d);
    rd(d);
    chk("kept", 8'hF7, d);
    $display("register test done");
  endtask
  task automatic smp(input logic signed [11:0] s, input logic signed [11:0] e);
    @(posedge clk_i);
    rx_sample_i <= s;
    rx_sample_valid_i <= 1'b1;
    @(posedge clk_i);
    rx_sample_valid_i <= 1'b0;
    #1 chk("sample", {e, 1'b1}, {demod_sample_o, demod_sample_valid_o});
  endtask
  task automatic chp(input logic b, input logic e, input logic r);
    @(posedge clk_i);
    tx_bit_i <= b;
    tx_chip_strobe_i <= 1'b1;
    @(posedge clk_i);
    tx_chip_strobe_i <= 1'b0;
    #1 chk("tx chip", e, tx_chip_o);
    chk("bit ready", r, tx_bit_ready_o);
  endtask
  task automatic t_data;
    wr(8'h02);
    smp(12'sh100, 12'sh100);
    smp(12'sh100, 12'sh0F0);
    wr(8'h82);
    smp(12'sh100, 12'sh100);
    chp(1'b1, 1'b1, 1'b1);
    wr(8'h0A);
    chk("bit ready", 1'b0, tx_bit_ready_o);
    chp(1'b0, 1'b0, 1'b1);
    chp(1'b0, 1'b1, 1'b0);
    $display("data path test done");
  endtask
  task automatic sy(input logic [7:0] c, input int s, input logic [31:0] w, input int n,
    input int e);
    int k;
    wr(c);
    @(posedge clk_i);
    carrier_sense_i <= 1'(s);
    rx_enable_i <= 1'b1;
    pword <= w;
    nbits <= 6'(n);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    #1;
    for (k = 0; k < 80 && busy; k++) #25;
    repeat (6) @(posedge clk_i);
    #1 chk("locked", e, rx_locked_o);
    @(posedge clk_i);
    rx_enable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_sync;
    logic [31:0] h, w;
    h = {sync_word_i, 16'h0};
    w = {sync_word_i, sync_word_i};
    sy(8'h02, 0, h, 16, 1);
    sy(8'h02, 0, h ^ 32'h10000, 16, 0);
    sy(8'h01, 0, h ^ 32'h10000, 16, 1);
    sy(8'h03, 0, w ^ 32'h3, 32, 1);
    sy(8'h03, 0, w ^ 32'h10003, 32, 0);
    sy(8'h06, 0, h, 16, 0);
    sy(8'h05, 1, h ^ 32'h10000, 16, 1);
    sy(8'h00, 0, 0, 0, 1);
    sy(8'h04, 0, 0, 0, 0);
    sy(8'h0A, 0, h, 16, 1);
    chk("manchester errors", 0, errs);
    $display("sync test done");
  endtask
  initial begin
    reset_i = 1'b1;
    {reg_wr_i, reg_rd_i, rx_sample_valid_i, tx_bit_i, tx_chip_strobe_i, go} = '0;
    {carrier_sense_i, rx_enable_i, reg_addr_i, reg_wdata_i, rx_sample_i, nbits, pword} = '0;
    sync_word_i = 16'hD391;
    miscompares = 0;
    tests_run = 0;
    errs = 0;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs;
    t_data;
    t_sync;
    give_verdict;
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    miscompares++;
    give_verdict;
  end
endmodule
